// [src/byte_crc16_generator.sv]
// byte-wide crc-16 / crc-ccitt unit behind an axi4-lite register slave
`timescale 1ns/100ps
`default_nettype none

// How it works
// - only the two fixed polynomials exist, crc-16 and crc-ccitt.
// - one select bit in the control register picks the polynomial.
// - checksum bits 15..8 sit in the high register, 7..0 in the low.
// - each input-register write with lane 0 enabled folds the byte into the held checksum.
// - one byte per write, folded in one cycle unless hold is set, readable right after.
// - the byte is xored into the checksum high byte first.
// - each bit step shifts left by one, zero into the lsb.
// - if the bit shifted out was one, xor in the polynomial constant.
// - the constant is 8005h for crc-16 and 1021h for ccitt.
// - eight such steps complete one byte.
// - bytes chain on the previous checksum; no final inversion.
// - select 0 is ccitt, 1 is crc-16, resets 0, other bits read 0.
// - input and both checksum registers are read/write, reset to zero.
module byte_crc16_generator
	import crc_regs_pkg::*;
#(
	parameter int STAGE_DEPTH = crc_regs_pkg::FIFO_DEPTH
) (
	input wire logic aclk, // system clock
	input wire logic aresetn, // synchronous reset, low
	input wire logic [crc_regs_pkg::ADDR_W-1:0] s_axi_awaddr, // write address
	input wire logic s_axi_awvalid, // write address valid
	output logic s_axi_awready, // write address taken
	input wire logic [crc_regs_pkg::DATA_W-1:0] s_axi_wdata, // write data
	input wire logic [3:0] s_axi_wstrb, // byte lane enables
	input wire logic s_axi_wvalid, // write data valid
	output logic s_axi_wready, // write data taken
	output logic [1:0] s_axi_bresp, // write response code
	output logic s_axi_bvalid, // write response valid
	input wire logic s_axi_bready, // master takes response
	input wire logic [crc_regs_pkg::ADDR_W-1:0] s_axi_araddr, // read address
	input wire logic s_axi_arvalid, // read address valid
	output logic s_axi_arready, // read address taken
	output logic [crc_regs_pkg::DATA_W-1:0] s_axi_rdata, // read data
	output logic [1:0] s_axi_rresp, // read response code
	output logic s_axi_rvalid, // read data valid
	input wire logic s_axi_rready // master takes read data
);
	import crc_regs_pkg::*;

	typedef enum logic [1:0] {
		WR_IDLE = 2'h1,
		WR_RESP = 2'h2
	} wr_state_t;

	typedef enum logic [1:0] {
		RD_IDLE = 2'h1,
		RD_RESP = 2'h2
	} rd_state_t;

	// write address and data holding
	logic aw_held_ff, nxt_aw_held;
	logic [ADDR_W-1:0] awaddr_ff, nxt_awaddr;
	logic awready_ff, nxt_awready;
	logic w_held_ff, nxt_w_held;
	logic [BYTE_W-1:0] w_byte_ff, nxt_w_byte;
	logic w_lane_ff, nxt_w_lane;
	logic wready_ff, nxt_wready;

	// write response
	wr_state_t wr_state_ff, nxt_wr_state;
	logic bvalid_ff, nxt_bvalid;
	logic [1:0] bresp_ff, nxt_bresp;

	// read channel
	rd_state_t rd_state_ff, nxt_rd_state;
	logic arready_ff, nxt_arready;
	logic rvalid_ff, nxt_rvalid;
	logic [DATA_W-1:0] rdata_ff, nxt_rdata;
	logic [1:0] rresp_ff, nxt_rresp;

	// block registers
	logic polynomial_select_ff, nxt_polynomial_select;
	logic hold_ff, nxt_hold;
	logic [BYTE_W-1:0] crc_input_byte_ff, nxt_crc_input_byte;
	logic [SUM_W-1:0] running_checksum_ff, nxt_running_checksum;

	// glue between bus, stage buffer and fold logic
	reg_sel_t wr_sel, rd_sel;
	logic aw_take, w_take, ar_take;
	logic apply, push, direct_load;
	logic stage_in_ready, stage_out_valid, stage_out_ready;
	logic [BYTE_W-1:0] stage_out_data;
	logic [SUM_W-1:0] folded_sum;
	logic fold_fire;

	// word-aligned decode; byte offsets inside a word are ignored
	function automatic reg_sel_t decode(input logic [ADDR_W-1:0] a);
		logic [ADDR_W-1:WORD_LSB] w;
		w = a[ADDR_W-1:WORD_LSB];
		if (w == OFS_CONTROL[ADDR_W-1:WORD_LSB]) begin
			return SEL_CONTROL;
		end else if (w == OFS_INPUT[ADDR_W-1:WORD_LSB]) begin
			return SEL_INPUT;
		end else if (w == OFS_LOW[ADDR_W-1:WORD_LSB]) begin
			return SEL_LOW;
		end else if (w == OFS_HIGH[ADDR_W-1:WORD_LSB]) begin
			return SEL_HIGH;
		end else if (w == OFS_ENGINE[ADDR_W-1:WORD_LSB]) begin
			return SEL_ENGINE;
		end
		return SEL_NONE;
	endfunction : decode

	assign wr_sel = decode(awaddr_ff);
	assign rd_sel = decode(s_axi_araddr);
	assign aw_take = s_axi_awvalid & awready_ff;
	assign w_take = s_axi_wvalid & wready_ff;
	assign ar_take = s_axi_arvalid & arready_ff;

	// a write is carried out once both halves are held; an input write
	// with lane 0 enabled waits while the stage buffer is full, which back-pressures the bus
	assign apply = (wr_state_ff == WR_IDLE) & aw_held_ff & w_held_ff
		& ((wr_sel != SEL_INPUT) | ~w_lane_ff | stage_in_ready);
	assign push = apply & (wr_sel == SEL_INPUT) & w_lane_ff;
	assign direct_load = apply & w_lane_ff & ((wr_sel == SEL_LOW) | (wr_sel == SEL_HIGH));

	// the fold stalls on the hold bit and whenever a seed load wins the cycle
	assign stage_out_ready = ~hold_ff & ~direct_load;
	assign fold_fire = stage_out_valid & stage_out_ready;

	// buffer so a stalled fold never drops a byte
	byte_stage_fifo #(
		.WIDTH(BYTE_W),
		.DEPTH(STAGE_DEPTH)
	) u_stage (
		.aclk(aclk),
		.aresetn(aresetn),
		.in_valid(push),
		.in_ready(stage_in_ready),
		.in_data(w_byte_ff),
		.out_valid(stage_out_valid),
		.out_ready(stage_out_ready),
		.out_data(stage_out_data)
	);

	// one byte against the current checksum and current select
	crc_byte_fold #(
		.BITS(BYTE_W)
	) u_fold (
		.sum_in(running_checksum_ff),
		.data_in(stage_out_data),
		.polynomial_select_sel(polynomial_select_ff),
		.sum_out(folded_sum)
	);

	// write address capture; released when the response is taken
	always_comb begin
		nxt_aw_held = aw_held_ff;
		nxt_awaddr = awaddr_ff;
		if (aw_take) begin
			nxt_aw_held = 1'b1;
			nxt_awaddr = s_axi_awaddr;
		end else if (bvalid_ff && s_axi_bready) begin
			nxt_aw_held = 1'b0;
		end
		nxt_awready = ~nxt_aw_held;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held_ff <= 1'b0;
			awaddr_ff <= '0;
			awready_ff <= 1'b0;
		end else begin
			aw_held_ff <= nxt_aw_held;
			awaddr_ff <= nxt_awaddr;
			awready_ff <= nxt_awready;
		end
	end

	// write data capture; only lane 0 carries register bits
	always_comb begin
		nxt_w_held = w_held_ff;
		nxt_w_byte = w_byte_ff;
		nxt_w_lane = w_lane_ff;
		if (w_take) begin
			nxt_w_held = 1'b1;
			nxt_w_byte = s_axi_wdata[BYTE_W-1:0];
			nxt_w_lane = s_axi_wstrb[LANE0];
		end else if (bvalid_ff && s_axi_bready) begin
			nxt_w_held = 1'b0;
		end
		nxt_wready = ~nxt_w_held;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			w_held_ff <= 1'b0;
			w_byte_ff <= BYTE_RESET;
			w_lane_ff <= 1'b0;
			wready_ff <= 1'b0;
		end else begin
			w_held_ff <= nxt_w_held;
			w_byte_ff <= nxt_w_byte;
			w_lane_ff <= nxt_w_lane;
			wready_ff <= nxt_wready;
		end
	end

	// write response sequencing
	always_comb begin
		nxt_wr_state = wr_state_ff;
		nxt_bvalid = bvalid_ff;
		nxt_bresp = bresp_ff;
		case (wr_state_ff)
			WR_IDLE: begin
				if (apply) begin
					nxt_wr_state = WR_RESP;
					nxt_bvalid = 1'b1;
					nxt_bresp = (wr_sel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
				end
			end
			WR_RESP: begin
				if (s_axi_bready) begin
					nxt_wr_state = WR_IDLE;
					nxt_bvalid = 1'b0;
					nxt_bresp = RESP_OKAY;
				end
			end
			default: begin
				nxt_wr_state = WR_IDLE;
				nxt_bvalid = 1'b0;
				nxt_bresp = RESP_OKAY;
			end
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			wr_state_ff <= WR_IDLE;
			bvalid_ff <= 1'b0;
			bresp_ff <= RESP_OKAY;
		end else begin
			wr_state_ff <= nxt_wr_state;
			bvalid_ff <= nxt_bvalid;
			bresp_ff <= nxt_bresp;
		end
	end

	// read sequencing; data is sampled from the registers at the take edge
	always_comb begin
		nxt_rd_state = rd_state_ff;
		nxt_arready = arready_ff;
		nxt_rvalid = rvalid_ff;
		nxt_rdata = rdata_ff;
		nxt_rresp = rresp_ff;
		case (rd_state_ff)
			RD_IDLE: begin
				nxt_arready = 1'b1;
				if (ar_take) begin
					nxt_rd_state = RD_RESP;
					nxt_arready = 1'b0;
					nxt_rvalid = 1'b1;
					nxt_rresp = RESP_OKAY;
					nxt_rdata = WORD_ZERO;
					case (rd_sel)
						SEL_CONTROL: nxt_rdata[POLYNOMIAL_SELECT_SEL_BIT] = polynomial_select_ff;
						SEL_INPUT: nxt_rdata[BYTE_W-1:0] = crc_input_byte_ff;
						SEL_LOW: nxt_rdata[BYTE_W-1:0] = running_checksum_ff[BYTE_W-1:0];
						SEL_HIGH: nxt_rdata[BYTE_W-1:0] = running_checksum_ff[SUM_W-1:BYTE_W];
						SEL_ENGINE: begin
							nxt_rdata[HOLD_BIT] = hold_ff;
							nxt_rdata[BUSY_BIT] = stage_out_valid;
						end
						default: nxt_rresp = RESP_SLVERR;
					endcase
				end
			end
			RD_RESP: begin
				if (s_axi_rready) begin
					nxt_rd_state = RD_IDLE;
					nxt_arready = 1'b1;
					nxt_rvalid = 1'b0;
				end
			end
			default: begin
				nxt_rd_state = RD_IDLE;
				nxt_arready = 1'b0;
				nxt_rvalid = 1'b0;
			end
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rd_state_ff <= RD_IDLE;
			arready_ff <= 1'b0;
			rvalid_ff <= 1'b0;
			rdata_ff <= WORD_ZERO;
			rresp_ff <= RESP_OKAY;
		end else begin
			rd_state_ff <= nxt_rd_state;
			arready_ff <= nxt_arready;
			rvalid_ff <= nxt_rvalid;
			rdata_ff <= nxt_rdata;
			rresp_ff <= nxt_rresp;
		end
	end

	// register updates; a seed load beats a fold in the same cycle,
	// which is safe because the fold is stalled for that cycle
	always_comb begin
		nxt_polynomial_select = polynomial_select_ff;
		nxt_hold = hold_ff;
		nxt_crc_input_byte = crc_input_byte_ff;
		nxt_running_checksum = running_checksum_ff;
		if (apply && w_lane_ff && wr_sel == SEL_CONTROL) begin
			nxt_polynomial_select = w_byte_ff[POLYNOMIAL_SELECT_SEL_BIT];
		end
		if (apply && w_lane_ff && wr_sel == SEL_ENGINE) begin
			nxt_hold = w_byte_ff[HOLD_BIT];
		end
		if (push) begin
			nxt_crc_input_byte = w_byte_ff;
		end
		if (direct_load) begin
			if (wr_sel == SEL_HIGH) begin
				nxt_running_checksum[SUM_W-1:BYTE_W] = w_byte_ff;
			end else begin
				nxt_running_checksum[BYTE_W-1:0] = w_byte_ff;
			end
		end else if (fold_fire) begin
			nxt_running_checksum = folded_sum;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			polynomial_select_ff <= POLYNOMIAL_SELECT_SEL_RESET;
			hold_ff <= HOLD_RESET;
			crc_input_byte_ff <= BYTE_RESET;
			running_checksum_ff <= SUM_RESET;
		end else begin
			polynomial_select_ff <= nxt_polynomial_select;
			hold_ff <= nxt_hold;
			crc_input_byte_ff <= nxt_crc_input_byte;
			running_checksum_ff <= nxt_running_checksum;
		end
	end

	// every bus output comes straight from its register
	assign s_axi_awready = awready_ff;
	assign s_axi_wready = wready_ff;
	assign s_axi_bvalid = bvalid_ff;
	assign s_axi_bresp = bresp_ff;
	assign s_axi_arready = arready_ff;
	assign s_axi_rvalid = rvalid_ff;
	assign s_axi_rdata = rdata_ff;
	assign s_axi_rresp = rresp_ff;
endmodule : byte_crc16_generator
`default_nettype wire

// [src/crc_regs_pkg.sv]
// register map, field positions, codes and constants of the byte crc unit
package crc_regs_pkg;
	localparam int ADDR_W = 5;
	localparam int DATA_W = 32;
	localparam int BYTE_W = 8;
	localparam int SUM_W = 16;
	localparam int WORD_LSB = 2;
	localparam int FIFO_DEPTH = 2;
	localparam logic [ADDR_W-1:0] OFS_CONTROL = 5'h00;
	localparam logic [ADDR_W-1:0] OFS_INPUT = 5'h04;
	localparam logic [ADDR_W-1:0] OFS_LOW = 5'h08;
	localparam logic [ADDR_W-1:0] OFS_HIGH = 5'h0C;
	localparam logic [ADDR_W-1:0] OFS_ENGINE = 5'h10;
	localparam int POLYNOMIAL_SELECT_SEL_BIT = 0;
	localparam int HOLD_BIT = 0;
	localparam int BUSY_BIT = 1;
	localparam int LANE0 = 0;
	localparam logic POLYNOMIAL_SELECT_SEL_RESET = 1'h0;
	localparam logic HOLD_RESET = 1'h0;
	localparam logic POLYNOMIAL_SELECT_IS_CRC16 = 1'h1;
	localparam logic [SUM_W-1:0] POLYNOMIAL_SELECT_CRC16 = 16'h8005;
	localparam logic [SUM_W-1:0] POLYNOMIAL_SELECT_CCITT = 16'h1021;
	localparam logic [SUM_W-1:0] SUM_RESET = 16'h0000;
	localparam logic [BYTE_W-1:0] BYTE_RESET = 8'h00;
	localparam logic [DATA_W-1:0] WORD_ZERO = 32'h00000000;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	// register selected by an address, one-hot
	typedef enum logic [5:0] {
		SEL_NONE = 6'h01,
		SEL_CONTROL = 6'h02,
		SEL_INPUT = 6'h04,
		SEL_LOW = 6'h08,
		SEL_HIGH = 6'h10,
		SEL_ENGINE = 6'h20
	} reg_sel_t;
endpackage : crc_regs_pkg

// [src/crc_byte_fold.sv]
// combinational fold of one byte into the 16-bit running checksum
`timescale 1ns/100ps
`default_nettype none
module crc_byte_fold
	import crc_regs_pkg::*;
#(
	parameter int BITS = crc_regs_pkg::BYTE_W
) (
	input wire logic [crc_regs_pkg::SUM_W-1:0] sum_in, // checksum before the byte
	input wire logic [BITS-1:0] data_in, // byte to fold in
	input wire logic polynomial_select_sel, // 1 crc-16, 0 ccitt
	output logic [crc_regs_pkg::SUM_W-1:0] sum_out // checksum after the byte
);
	import crc_regs_pkg::*;

	// one shift with conditional xor, keyed on the bit shifted out
	function automatic logic [SUM_W-1:0] shift_step(input logic [SUM_W-1:0] v,
			input logic [SUM_W-1:0] polynomial_select);
		logic [SUM_W-1:0] shifted;
		shifted = {v[SUM_W-2:0], 1'b0};
		return v[SUM_W-1] ? (shifted ^ polynomial_select) : shifted;
	endfunction : shift_step

	// only the two fixed constants exist; nothing is programmable
	always_comb begin
		logic [SUM_W-1:0] polynomial_select;
		logic [SUM_W-1:0] tmp;
		polynomial_select = (polynomial_select_sel == POLYNOMIAL_SELECT_IS_CRC16) ? POLYNOMIAL_SELECT_CRC16 : POLYNOMIAL_SELECT_CCITT;
		tmp = sum_in ^ (SUM_W'(data_in) << (SUM_W - BITS));
		for (int i = 0; i < BITS; i++) begin
			tmp = shift_step(tmp, polynomial_select);
		end
		sum_out = tmp;
	end
endmodule : crc_byte_fold
`default_nettype wire

// [src/byte_stage_fifo.sv]
// small flip-flop fifo with valid and ready on both sides
`timescale 1ns/100ps
`default_nettype none
module byte_stage_fifo
	import crc_regs_pkg::*;
#(
	parameter int WIDTH = crc_regs_pkg::BYTE_W,
	parameter int DEPTH = crc_regs_pkg::FIFO_DEPTH
) (
	input wire logic aclk, // system clock
	input wire logic aresetn, // synchronous reset, low
	input wire logic in_valid, // word offered
	output logic in_ready, // room for a word
	input wire logic [WIDTH-1:0] in_data, // word in
	output logic out_valid, // word waiting
	input wire logic out_ready, // consumer takes word
	output logic [WIDTH-1:0] out_data // oldest word
);
	import crc_regs_pkg::*;
	localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam int CNT_W = $clog2(DEPTH + 1);
	localparam logic [PTR_W-1:0] LAST = PTR_W'(DEPTH - 1);
	localparam logic [CNT_W-1:0] FULL = CNT_W'(DEPTH);

	logic [WIDTH-1:0] mem_ff [DEPTH];
	logic [WIDTH-1:0] nxt_mem [DEPTH];
	logic [PTR_W-1:0] wptr_ff, nxt_wptr, rptr_ff, nxt_rptr;
	logic [CNT_W-1:0] count_ff, nxt_count;
	logic push, pop;

	// honest flags straight from the occupancy count
	assign in_ready = (count_ff != FULL);
	assign out_valid = (count_ff != '0);
	assign out_data = mem_ff[rptr_ff];
	assign push = in_valid & in_ready;
	assign pop = out_valid & out_ready;

	// pointer and storage update
	always_comb begin
		nxt_mem = mem_ff;
		nxt_wptr = wptr_ff;
		nxt_rptr = rptr_ff;
		nxt_count = count_ff;
		if (push) begin
			nxt_mem[wptr_ff] = in_data;
			nxt_wptr = (wptr_ff == LAST) ? '0 : wptr_ff + 1'b1;
		end
		if (pop) begin
			nxt_rptr = (rptr_ff == LAST) ? '0 : rptr_ff + 1'b1;
		end
		if (push && !pop) begin
			nxt_count = count_ff + 1'b1;
		end else if (pop && !push) begin
			nxt_count = count_ff - 1'b1;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			wptr_ff <= '0;
			rptr_ff <= '0;
			count_ff <= '0;
			for (int i = 0; i < DEPTH; i++) begin
				mem_ff[i] <= '0;
			end
		end else begin
			wptr_ff <= nxt_wptr;
			rptr_ff <= nxt_rptr;
			count_ff <= nxt_count;
			mem_ff <= nxt_mem;
		end
	end
endmodule : byte_stage_fifo
`default_nettype wire

// [tb/crc_gen_asserts.sv]
// bus-timing and read-value checker for the byte crc unit
`timescale 1ns/100ps
`default_nettype none
module crc_gen_checker
	import crc_regs_pkg::*;
(
	input wire logic aclk, // clock
	input wire logic aresetn, // reset, low
	input wire logic [crc_regs_pkg::ADDR_W-1:0] s_axi_awaddr, // aw
	input wire logic s_axi_awvalid, // aw
	input wire logic s_axi_awready, // aw
	input wire logic [crc_regs_pkg::DATA_W-1:0] s_axi_wdata, // w
	input wire logic [3:0] s_axi_wstrb, // w
	input wire logic s_axi_wvalid, // w
	input wire logic s_axi_wready, // w
	input wire logic [1:0] s_axi_bresp, // b
	input wire logic s_axi_bvalid, // b
	input wire logic s_axi_bready, // b
	input wire logic [crc_regs_pkg::ADDR_W-1:0] s_axi_araddr, // ar
	input wire logic s_axi_arvalid, // ar
	input wire logic s_axi_arready, // ar
	input wire logic [crc_regs_pkg::DATA_W-1:0] s_axi_rdata, // r
	input wire logic [1:0] s_axi_rresp, // r
	input wire logic s_axi_rvalid, // r
	input wire logic s_axi_rready // r
);
	// one clock domain, so clock and reset are stated once
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);
	b_held_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped early");
	r_held_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped early");
	read_latency_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && s_axi_rdata[31:8] == 24'h0)
		else $error("read answer late or wide");
	control_bits_a: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr[4:2] == 3'h0
		|=> s_axi_rdata[31:1] == 31'h0) else $error("control spare bits not zero");
	read_unmapped_a: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr[4:2] > 3'h4
		|=> s_axi_rresp == RESP_SLVERR && s_axi_rdata == WORD_ZERO) else $error("unmapped read answered");
	// writes that never enter the stage buffer: held at the take edge, applied next, answered after that
	write_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
		&& (s_axi_awaddr[4:2] != 3'h1 || !s_axi_wstrb[0])
		|=> !s_axi_bvalid ##1 s_axi_bvalid
		&& s_axi_bresp == ($past(s_axi_awaddr[4:2], 2) > 3'h4 ? RESP_SLVERR : RESP_OKAY))
		else $error("write answer wrong");
	write_busy_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("write taken while answering");
	read_busy_a: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read taken while answering");
	write_reopen_a: assert property (s_axi_bvalid && s_axi_bready |-> ##[1:2] s_axi_awready && s_axi_wready)
		else $error("write channel not reopened");
endmodule : crc_gen_checker
bind byte_crc16_generator crc_gen_checker u_chk (.aclk(aclk), .aresetn(aresetn),
	.s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
	.s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
	.s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
	.s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
	.s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));
`default_nettype wire

// [tb/test_byte_crc16_generator.sv]
// self-checking bench of the byte crc unit over its register bus
`timescale 1ns/100ps
`default_nettype none
module test_byte_crc16_generator;
	import crc_regs_pkg::*;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic [ADDR_W-1:0] awaddr = 5'h00, araddr = 5'h00;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic [DATA_W-1:0] wdata = 32'h00000000;
	logic [3:0] wstrb = 4'hF;
	logic awready, wready, bvalid, arready, rvalid;
	logic [1:0] bresp, rresp;
	logic [DATA_W-1:0] rdata;
	int fail_count = 0;
	int comparisons = 0;
	int cycles = 0;
	logic [31:0] rng = 32'h00013EA4;
	byte_crc16_generator u_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
		.s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
	always #5 aclk = ~aclk;
	task automatic end_of_test;
		if (fail_count == 0 && comparisons > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : end_of_test
	// the whole run needs under two thousand cycles; a hang stops here
	always @(posedge aclk) begin
		cycles = cycles + 1;
		if (cycles == 20000) begin
			fail_count++;
			end_of_test();
		end
	end
	function automatic logic [31:0] xorshift();
		rng = rng ^ (rng << 13);
		rng = rng ^ (rng >> 17);
		rng = rng ^ (rng << 5);
		return rng;
	endfunction : xorshift
	// reference fold: msb out selects the xor after each shift
	function automatic logic [15:0] fold(logic [15:0] s, logic [7:0] b, logic p);
		s = s ^ {b, 8'h00};
		for (int i = 0; i < 8; i++)
			s = s[15] ? ((s << 1) ^ (p ? 16'h8005 : 16'h1021)) : (s << 1);
		return s;
	endfunction : fold
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
			fail_count++;
		end
	endtask : check
	// address and data offered together, each dropped at its own take
	task automatic wr(input logic [4:0] a, input logic [31:0] d, input logic [3:0] s, output logic [1:0] r);
		bit aw_done;
		bit w_done;
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		wstrb <= s;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		aw_done = 0;
		w_done = 0;
		while (!(aw_done && w_done)) begin
			@(posedge aclk);
			if (!aw_done && awready === 1'b1) begin
				aw_done = 1;
				awvalid <= 1'b0;
			end
			if (!w_done && wready === 1'b1) begin
				w_done = 1;
				wvalid <= 1'b0;
			end
		end
		// a late bready makes the response wait, so its holding is exercised
		repeat (rng[1:0]) @(posedge aclk);
		bready <= 1'b1;
		do @(posedge aclk); while (bvalid !== 1'b1);
		r = bresp;
		bready <= 1'b0;
	endtask : wr
	task automatic rd(input logic [4:0] a, output logic [31:0] d, output logic [1:0] r);
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		do @(posedge aclk); while (arready !== 1'b1);
		arvalid <= 1'b0;
		repeat (rng[1:0]) @(posedge aclk);
		rready <= 1'b1;
		do @(posedge aclk); while (rvalid !== 1'b1);
		d = rdata;
		r = rresp;
		rready <= 1'b0;
	endtask : rd
	task automatic wr_ok(input logic [4:0] a, input logic [31:0] d);
		logic [1:0] r;
		wr(a, d, 4'hF, r);
		check({30'h0, r}, {30'h0, RESP_OKAY});
	endtask : wr_ok
	task automatic rd_chk(input logic [4:0] a, input logic [31:0] exp);
		logic [31:0] d;
		logic [1:0] r;
		rd(a, d, r);
		check(d, exp);
		check({30'h0, r}, {30'h0, RESP_OKAY});
	endtask : rd_chk
	// checksum halves read apart: high holds 15..8, low 7..0
	task automatic sum_chk(input logic [15:0] exp);
		rd_chk(OFS_LOW, {24'h0, exp[7:0]});
		rd_chk(OFS_HIGH, {24'h0, exp[15:8]});
	endtask : sum_chk
	task automatic clear_sum;
		wr_ok(OFS_LOW, 32'h0);
		wr_ok(OFS_HIGH, 32'h0);
	endtask : clear_sum
	initial begin
		logic [31:0] d;
		logic [1:0] r;
		logic [15:0] s;
		logic p;
		repeat (12) @(posedge aclk);
		aresetn <= 1'b1;
		rd_chk(OFS_CONTROL, 32'h0);
		rd_chk(OFS_INPUT, 32'h0);
		sum_chk(16'h0000);
		wr_ok(OFS_CONTROL, 32'hFFFFFFFF);
		rd_chk(OFS_CONTROL, 32'h1);
		// one byte from zero under each select value
		for (int q = 0; q < 2; q++) begin
			for (int b = 0; b < 8; b++) begin
				wr_ok(OFS_CONTROL, 32'(q));
				clear_sum();
				wr_ok(OFS_INPUT, 32'(b));
				rd_chk(OFS_INPUT, 32'(b));
				sum_chk(fold(16'h0, 8'(b), q[0]));
			end
			// four-byte chain with known results
			clear_sum();
			wr_ok(OFS_INPUT, 32'h78);
			wr_ok(OFS_INPUT, 32'h56);
			wr_ok(OFS_INPUT, 32'h34);
			wr_ok(OFS_INPUT, 32'h12);
			sum_chk(q ? 16'h5C43 : 16'hD0FA);
		end
		// seed load without folding, then chain from it
		wr_ok(OFS_LOW, 32'h34);
		wr_ok(OFS_HIGH, 32'h12);
		sum_chk(16'h1234);
		wr_ok(OFS_INPUT, 32'hAB);
		s = fold(16'h1234, 8'hAB, 1'b1);
		sum_chk(s);
		// lane 0 disabled leaves the checksum alone
		wr(OFS_INPUT, 32'h55, 4'hE, r);
		check({30'h0, r}, {30'h0, RESP_OKAY});
		sum_chk(s);
		// unmapped places answer with an error
		wr(5'h14, 32'hFF, 4'hF, r);
		check({30'h0, r}, {30'h0, RESP_SLVERR});
		rd(5'h18, d, r);
		check(d, WORD_ZERO);
		check({30'h0, r}, {30'h0, RESP_SLVERR});
		// hold fills the stage buffer; release drains it in order
		wr_ok(OFS_ENGINE, 32'h1);
		wr_ok(OFS_INPUT, 32'hC3);
		wr_ok(OFS_INPUT, 32'h3C);
		rd_chk(OFS_ENGINE, 32'h3);
		sum_chk(s);
		wr_ok(OFS_ENGINE, 32'h0);
		rd_chk(OFS_ENGINE, 32'h0);
		s = fold(fold(s, 8'hC3, 1'b1), 8'h3C, 1'b1);
		sum_chk(s);
		// random words fed low byte first, select changed between words
		clear_sum();
		s = 16'h0;
		for (int w = 0; w < 40; w++) begin
			p = xorshift() > 32'h7FFFFFFF;
			wr_ok(OFS_CONTROL, {31'h0, p});
			d = xorshift();
			wr_ok(OFS_INPUT, d);
			wr_ok(OFS_INPUT, d >> 8);
			s = fold(fold(s, d[7:0], p), d[15:8], p);
			sum_chk(s);
			repeat (d[17:16]) @(posedge aclk);
		end
		end_of_test();
	end
endmodule : test_byte_crc16_generator
`default_nettype wire
